/* File: rtl/ddc_pkg.sv */
package ddc_pkg;

    // register byte addresses
    localparam logic [15:0] DDC_ADDR_PHASE_MSB = 16'h0362;
    localparam logic [15:0] DDC_ADDR_TEST_EN = 16'h0367;
    localparam logic [15:0] DDC_ADDR_MIX_CTRL = 16'h0370;
    localparam logic [15:0] DDC_ADDR_INSEL = 16'h0371;

    // reset values
    localparam logic [7:0] DDC_RST_PHASE_MSB = 8'h00;
    localparam logic [7:0] DDC_RST_TEST_EN = 8'h00;
    localparam logic [7:0] DDC_RST_MIX_CTRL = 8'h00;
    localparam logic [7:0] DDC_RST_INSEL = 8'h04;

    // writable bits per register, the rest read as zero
    localparam logic [7:0] DDC_MASK_PHASE_MSB = 8'hff;
    localparam logic [7:0] DDC_MASK_TEST_EN = 8'h05;
    localparam logic [7:0] DDC_MASK_MIX_CTRL = 8'hff;
    localparam logic [7:0] DDC_MASK_INSEL = 8'hf5;

    // field positions
    localparam int DDC_TEST_Q_BIT = 2;
    localparam int DDC_TEST_I_BIT = 0;
    localparam int DDC_MIX_BIT = 7;
    localparam int DDC_GAIN_BIT = 6;
    localparam int DDC_IF_HI = 5;
    localparam int DDC_IF_LO = 4;
    localparam int DDC_C2R_BIT = 3;
    localparam int DDC_DEC_HI = 2;
    localparam int DDC_DEC_LO = 0;
    localparam int DDC_EXT_HI = 7;
    localparam int DDC_EXT_LO = 4;
    localparam int DDC_INSEL_Q_BIT = 2;
    localparam int DDC_INSEL_I_BIT = 0;

    // sample limits
    localparam logic [15:0] DDC_SMP_MAX = 16'h7fff;
    localparam logic [15:0] DDC_SMP_MIN = 16'h8000;

    // buffer depth
    localparam logic [1:0] DDC_BUF_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        DDC_IF_VAR = 2'b00,
        DDC_IF_ZERO = 2'b01,
        DDC_IF_FS = 2'b10,
        DDC_IF_TEST = 2'b11
    } ddc_if_mode_t;

    typedef enum logic [2:0] {
        DDC_DEC_HB12 = 3'b000,
        DDC_DEC_HB123 = 3'b001,
        DDC_DEC_HB1234 = 3'b010,
        DDC_DEC_HB1 = 3'b011,
        DDC_DEC_HB1_TB = 3'b100,
        DDC_DEC_HB12_TB = 3'b101,
        DDC_DEC_HB123_TB = 3'b110,
        DDC_DEC_EXT = 3'b111
    } ddc_dec_t;

    typedef enum logic [3:0] {
        DDC_EXT_TB_HB1234 = 4'b0000,
        DDC_EXT_FB_HB1 = 4'b0010,
        DDC_EXT_FB_HB12 = 4'b0011,
        DDC_EXT_FB_HB123 = 4'b0100
    } ddc_ext_t;

    // complex-output decimation ratios
    localparam logic [5:0] DDC_R_HB12 = 6'h04;
    localparam logic [5:0] DDC_R_HB123 = 6'h08;
    localparam logic [5:0] DDC_R_HB1234 = 6'h10;
    localparam logic [5:0] DDC_R_HB1 = 6'h02;
    localparam logic [5:0] DDC_R_HB1_TB = 6'h06;
    localparam logic [5:0] DDC_R_HB12_TB = 6'h0c;
    localparam logic [5:0] DDC_R_HB123_TB = 6'h18;
    localparam logic [5:0] DDC_R_TB_HB1234 = 6'h30;
    localparam logic [5:0] DDC_R_FB_HB1 = 6'h0a;
    localparam logic [5:0] DDC_R_FB_HB12 = 6'h14;
    localparam logic [5:0] DDC_R_FB_HB123 = 6'h28;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } ddc_iq_t;

endpackage

/* File: rtl/ddc_decim.sv */
`timescale 1ns/100ps
module ddc_decim (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // incoming samples
    input wire logic i_valid,
    input wire ddc_pkg::ddc_iq_t i_smp,
    // configuration
    input wire logic [5:0] i_ratio,
    input wire logic i_c2r,
    // outgoing samples
    output logic o_valid,
    output ddc_pkg::ddc_iq_t o_smp
);

    typedef struct packed {
        logic [5:0] cnt;
        logic flip;
        logic valid;
        ddc_pkg::ddc_iq_t smp;
    } ddc_dec_state_t;

    ddc_dec_state_t st_reg;
    ddc_dec_state_t st_next;

    // keep one sample in every ratio; real output flips sign on alternate words
    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        if (i_valid) begin
            if ((st_reg.cnt + 6'h01) >= i_ratio) begin
                st_next.cnt = 6'h00;
                st_next.valid = 1'b1;
                st_next.flip = ~st_reg.flip;
                if (i_c2r) begin
                    if (!st_reg.flip) begin
                        st_next.smp.i = i_smp.i;
                    end else if (i_smp.i == ddc_pkg::DDC_SMP_MIN) begin
                        st_next.smp.i = ddc_pkg::DDC_SMP_MAX;
                    end else begin
                        st_next.smp.i = 16'h0000 - i_smp.i;
                    end
                    st_next.smp.q = 16'h0000;
                end else begin
                    st_next.smp = i_smp;
                end
            end else begin
                st_next.cnt = st_reg.cnt + 6'h01;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_valid = st_reg.valid;
    assign o_smp = st_reg.smp;

endmodule

/* File: rtl/ddc_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - byte register holds phase offset bits 47:40, reset zero
// - test bit 2 routes second downconverter Q from pattern generator B
// - test bit 0 routes second downconverter I from pattern generator A
// - mixer bit 7: clear uses one real channel, set separate channels
// - gain bit 6 set doubles downconverted samples, clear leaves them
// - complex-to-real bit 3 set outputs real I only via fs mixing
// - codes 000,001,010 decimate by 4,8,16 complex, half when real
// - code 011 decimates by 2 complex, 1 when real
// - codes 100,101,110 decimate by 6,12,24 complex, half when real
// - code 111 takes the ratio from the extended field bits 7:4
// - extended field is used only while primary field is all ones
// - extended code 000 decimates by 48 complex, 24 real
// - extended codes 010,011,100 decimate by 10,20,40, half when real
module ddc_top (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // converter channel samples for the third downconverter
    input wire logic i_smp_valid,
    input wire logic [15:0] i_cha,
    input wire logic [15:0] i_chb,
    output logic o_smp_ready,
    // decimated output toward the framer
    output logic o_out_valid,
    output ddc_pkg::ddc_iq_t o_out,
    input wire logic i_out_ready,
    // second downconverter output and test patterns
    input wire logic i_dc2_valid,
    input wire ddc_pkg::ddc_iq_t i_dc2,
    input wire logic [15:0] i_pat_a,
    input wire logic [15:0] i_pat_b,
    output logic o_dc2_valid,
    output ddc_pkg::ddc_iq_t o_dc2,
    // configuration seen by the oscillator
    output logic [7:0] o_phase_offset_msb,
    output ddc_pkg::ddc_if_mode_t o_if_mode
);

    typedef struct packed {
        logic [7:0] phase_msb;
        logic [7:0] test_en;
        logic [7:0] mix_ctrl;
        logic [7:0] insel;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] cnt;
        ddc_pkg::ddc_iq_t ent0;
        ddc_pkg::ddc_iq_t ent1;
        logic ovalid;
        logic ready;
        logic dc2_valid;
        ddc_pkg::ddc_iq_t dc2;
        ddc_pkg::ddc_if_mode_t if_mode;
    } ddc_state_t;

    ddc_state_t st_reg;
    ddc_state_t st_next;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic accept;
    logic [15:0] ch_i;
    logic [15:0] ch_q;
    ddc_pkg::ddc_iq_t mixed;
    logic [5:0] ratio;
    logic dec_valid;
    ddc_pkg::ddc_iq_t dec_smp;
    logic pop;

    // reset release through two flip-flops
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // saturating doubling of one sample
    function automatic logic [15:0] ddc_double(input logic [15:0] s);
        logic [15:0] r;
        r = {s[14:0], 1'b0};
        if (s[15] != s[14]) begin
            r = s[15] ? ddc_pkg::DDC_SMP_MIN : ddc_pkg::DDC_SMP_MAX;
        end
        return r;
    endfunction

    // decimation ratio from the primary and extended fields, halved for real output
    function automatic logic [5:0] ddc_ratio(input logic [2:0] dec, input logic [3:0] ext, input logic c2r);
        logic [5:0] r;
        r = ddc_pkg::DDC_R_TB_HB1234;
        case (dec)
            ddc_pkg::DDC_DEC_HB12: begin
                r = ddc_pkg::DDC_R_HB12;
            end
            ddc_pkg::DDC_DEC_HB123: begin
                r = ddc_pkg::DDC_R_HB123;
            end
            ddc_pkg::DDC_DEC_HB1234: begin
                r = ddc_pkg::DDC_R_HB1234;
            end
            ddc_pkg::DDC_DEC_HB1: begin
                r = ddc_pkg::DDC_R_HB1;
            end
            ddc_pkg::DDC_DEC_HB1_TB: begin
                r = ddc_pkg::DDC_R_HB1_TB;
            end
            ddc_pkg::DDC_DEC_HB12_TB: begin
                r = ddc_pkg::DDC_R_HB12_TB;
            end
            ddc_pkg::DDC_DEC_HB123_TB: begin
                r = ddc_pkg::DDC_R_HB123_TB;
            end
            default: begin
                case (ext)
                    ddc_pkg::DDC_EXT_FB_HB1: begin
                        r = ddc_pkg::DDC_R_FB_HB1;
                    end
                    ddc_pkg::DDC_EXT_FB_HB12: begin
                        r = ddc_pkg::DDC_R_FB_HB12;
                    end
                    ddc_pkg::DDC_EXT_FB_HB123: begin
                        r = ddc_pkg::DDC_R_FB_HB123;
                    end
                    default: begin
                        r = ddc_pkg::DDC_R_TB_HB1234;
                    end
                endcase
            end
        endcase
        // real output halves every ratio
        if (c2r) begin
            r = {1'b0, r[5:1]};
        end
        return r;
    endfunction

    // input select and mixer type
    always_comb begin
        ch_i = st_reg.insel[ddc_pkg::DDC_INSEL_I_BIT] ? i_chb : i_cha;
        ch_q = st_reg.insel[ddc_pkg::DDC_INSEL_Q_BIT] ? i_chb : i_cha;
        if (!st_reg.mix_ctrl[ddc_pkg::DDC_MIX_BIT]) begin
            ch_q = ch_i;
        end
        mixed.i = ch_i;
        mixed.q = ch_q;
        if (st_reg.mix_ctrl[ddc_pkg::DDC_GAIN_BIT]) begin
            mixed.i = ddc_double(ch_i);
            mixed.q = ddc_double(ch_q);
        end
    end

    assign accept = i_smp_valid && st_reg.ready;
    assign ratio = ddc_ratio(st_reg.mix_ctrl[ddc_pkg::DDC_DEC_HI:ddc_pkg::DDC_DEC_LO],
                             st_reg.insel[ddc_pkg::DDC_EXT_HI:ddc_pkg::DDC_EXT_LO],
                             st_reg.mix_ctrl[ddc_pkg::DDC_C2R_BIT]);
    assign pop = st_reg.ovalid && i_out_ready;

    // decimation stage
    ddc_decim u_decim (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_valid(accept),
        .i_smp(mixed),
        .i_ratio(ratio),
        .i_c2r(st_reg.mix_ctrl[ddc_pkg::DDC_C2R_BIT]),
        .o_valid(dec_valid),
        .o_smp(dec_smp)
    );

    // registers, buffer and second downconverter path
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        // register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                ddc_pkg::DDC_ADDR_PHASE_MSB: begin
                    st_next.phase_msb = i_reg_wdata & ddc_pkg::DDC_MASK_PHASE_MSB;
                end
                ddc_pkg::DDC_ADDR_TEST_EN: begin
                    st_next.test_en = i_reg_wdata & ddc_pkg::DDC_MASK_TEST_EN;
                end
                ddc_pkg::DDC_ADDR_MIX_CTRL: begin
                    st_next.mix_ctrl = i_reg_wdata & ddc_pkg::DDC_MASK_MIX_CTRL;
                end
                ddc_pkg::DDC_ADDR_INSEL: begin
                    st_next.insel = i_reg_wdata & ddc_pkg::DDC_MASK_INSEL;
                end
                default: begin
                    st_next.insel = st_reg.insel;
                end
            endcase
        end
        // register reads, unmapped addresses return zero
        if (i_reg_rd) begin
            st_next.rvalid = 1'b1;
            case (i_reg_addr)
                ddc_pkg::DDC_ADDR_PHASE_MSB: begin
                    st_next.rdata = st_reg.phase_msb;
                end
                ddc_pkg::DDC_ADDR_TEST_EN: begin
                    st_next.rdata = st_reg.test_en;
                end
                ddc_pkg::DDC_ADDR_MIX_CTRL: begin
                    st_next.rdata = st_reg.mix_ctrl;
                end
                ddc_pkg::DDC_ADDR_INSEL: begin
                    st_next.rdata = st_reg.insel;
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
        st_next.if_mode = ddc_pkg::ddc_if_mode_t'(st_reg.mix_ctrl[ddc_pkg::DDC_IF_HI:ddc_pkg::DDC_IF_LO]);
        // two-entry buffer: pop from the head, push behind it
        case ({dec_valid, pop})
            2'b10: begin
                if (st_reg.cnt == 2'h0) begin
                    st_next.ent0 = dec_smp;
                end else begin
                    st_next.ent1 = dec_smp;
                end
                st_next.cnt = st_reg.cnt + 2'h1;
            end
            2'b01: begin
                st_next.ent0 = st_reg.ent1;
                st_next.cnt = st_reg.cnt - 2'h1;
            end
            2'b11: begin
                if (st_reg.cnt == 2'h1) begin
                    st_next.ent0 = dec_smp;
                end else begin
                    st_next.ent0 = st_reg.ent1;
                    st_next.ent1 = dec_smp;
                end
            end
            default: begin
                st_next.cnt = st_reg.cnt;
            end
        endcase
        st_next.ovalid = (st_next.cnt != 2'h0);
        // accept only if a word in flight still finds a free entry
        st_next.ready = ((st_next.cnt + {1'b0, accept}) < ddc_pkg::DDC_BUF_DEPTH);
        // second downconverter output with test pattern substitution
        st_next.dc2_valid = i_dc2_valid;
        if (i_dc2_valid) begin
            st_next.dc2 = i_dc2;
            if (st_reg.test_en[ddc_pkg::DDC_TEST_I_BIT]) begin
                st_next.dc2.i = i_pat_a;
            end
            if (st_reg.test_en[ddc_pkg::DDC_TEST_Q_BIT]) begin
                st_next.dc2.q = i_pat_b;
            end
        end
    end

    // state register with documented defaults
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.phase_msb <= ddc_pkg::DDC_RST_PHASE_MSB;
            st_reg.test_en <= ddc_pkg::DDC_RST_TEST_EN;
            st_reg.mix_ctrl <= ddc_pkg::DDC_RST_MIX_CTRL;
            st_reg.insel <= ddc_pkg::DDC_RST_INSEL;
            st_reg.if_mode <= ddc_pkg::DDC_IF_VAR;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign o_reg_rdata = st_reg.rdata;
    assign o_reg_rvalid = st_reg.rvalid;
    assign o_smp_ready = st_reg.ready;
    assign o_out_valid = st_reg.ovalid;
    assign o_out = st_reg.ent0;
    assign o_dc2_valid = st_reg.dc2_valid;
    assign o_dc2 = st_reg.dc2;
    assign o_phase_offset_msb = st_reg.phase_msb;
    assign o_if_mode = st_reg.if_mode;

endmodule

/* File: verif/ddc_properties.sv */
`timescale 1ns/100ps
module ddc_properties (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // output stream
    input wire logic o_out_valid,
    input wire ddc_pkg::ddc_iq_t o_out,
    input wire logic i_out_ready,
    // second downconverter path
    input wire logic i_dc2_valid,
    input wire ddc_pkg::ddc_iq_t i_dc2,
    input wire logic [15:0] i_pat_a,
    input wire logic [15:0] i_pat_b,
    input wire logic o_dc2_valid,
    input wire ddc_pkg::ddc_iq_t o_dc2,
    // oscillator configuration
    input wire logic [7:0] o_phase_offset_msb,
    input wire ddc_pkg::ddc_if_mode_t o_if_mode
);
    logic [7:0] ten_h;
    logic [7:0] ctl_h;
    logic [7:0] sel_h;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    // shadow copies of the writable bits
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ten_h <= 8'h00;
            ctl_h <= 8'h00;
            sel_h <= 8'h04;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ddc_pkg::DDC_ADDR_TEST_EN) ten_h <= i_reg_wdata & 8'h05;
            if (i_reg_addr == ddc_pkg::DDC_ADDR_MIX_CTRL) ctl_h <= i_reg_wdata;
            if (i_reg_addr == ddc_pkg::DDC_ADDR_INSEL) sel_h <= i_reg_wdata & 8'hf5;
        end
    end
    sequence s_wr(logic [15:0] a);
        i_reg_wr && i_reg_addr == a;
    endsequence
    sequence s_rd(logic [15:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    property p_phase;
        s_wr(ddc_pkg::DDC_ADDR_PHASE_MSB) |=> o_phase_offset_msb == $past(i_reg_wdata);
    endproperty
    a_phase: assert property (p_phase) else $error("phase byte not updated");
    property p_rd_test;
        s_rd(ddc_pkg::DDC_ADDR_TEST_EN) |=> o_reg_rvalid && o_reg_rdata == $past(ten_h);
    endproperty
    a_rd_test: assert property (p_rd_test) else $error("test enable readback wrong");
    property p_rd_ctl;
        s_rd(ddc_pkg::DDC_ADDR_MIX_CTRL) |=> o_reg_rvalid && o_reg_rdata == $past(ctl_h);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
    property p_rd_sel;
        s_rd(ddc_pkg::DDC_ADDR_INSEL) |=> o_reg_rvalid && o_reg_rdata == $past(sel_h);
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("input select readback wrong");
    property p_if_mode;
        s_wr(ddc_pkg::DDC_ADDR_MIX_CTRL) |=> ##1 o_if_mode == $past(i_reg_wdata[5:4], 2);
    endproperty
    a_if_mode: assert property (p_if_mode) else $error("if mode not exported");
    property p_dc2_i;
        i_dc2_valid |=> o_dc2_valid && o_dc2.i == ($past(ten_h[0]) ? $past(i_pat_a) : $past(i_dc2.i));
    endproperty
    a_dc2_i: assert property (p_dc2_i) else $error("i pattern routing wrong");
    property p_dc2_q;
        i_dc2_valid |=> o_dc2_valid && o_dc2.q == ($past(ten_h[2]) ? $past(i_pat_b) : $past(i_dc2.q));
    endproperty
    a_dc2_q: assert property (p_dc2_q) else $error("q pattern routing wrong");
    property p_real_q;
        o_out_valid && ctl_h[3] |-> o_out.q == 16'h0000;
    endproperty
    a_real_q: assert property (p_real_q) else $error("q not zero in real mode");
    property p_hold;
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output word dropped while stalled");
endmodule
bind ddc_top ddc_properties ddc_properties_i (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_out_valid, .o_out, .i_out_ready, .i_dc2_valid, .i_dc2,
    .i_pat_a, .i_pat_b, .o_dc2_valid, .o_dc2, .o_phase_offset_msb, .o_if_mode);

/* File: verif/ddc_src_model.sv */
`timescale 1ns/100ps
module ddc_src_model (
    // clock and control
    input wire logic i_mclk,
    input wire logic i_clr,
    input wire logic i_run,
    input wire logic i_slow,
    // sample handshake
    input wire logic i_ready,
    output logic o_valid,
    output logic [15:0] o_cha,
    output logic [15:0] o_chb
);
    logic acc = 1'b0;
    logic tog = 1'b0;
    logic [15:0] n = 16'h0000;
    initial o_valid = 1'b0;
    initial o_cha = 16'h0000;
    initial o_chb = 16'h0000;
    // note whether the shown sample was taken
    always @(posedge i_mclk) acc <= o_valid && i_ready;
    // hold until taken, idle data toggles so it never looks stable
    always @(negedge i_mclk) begin
        tog = ~tog;
        if (i_clr) begin
            n = 16'h0000;
            o_valid = 1'b0;
        end else if (!o_valid || acc) begin
            if (acc) n = n + 16'h0001;
            if (i_run && !(i_slow && tog)) begin
                o_valid = 1'b1;
                o_cha = 16'h0100 + n;
                o_chb = 16'h7000 + n;
            end else begin
                o_valid = 1'b0;
                o_cha = ~o_cha;
                o_chb = ~o_chb;
            end
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_out_ready = 1'b0;
    logic i_dc2_valid = 1'b0;
    logic [15:0] i_pat_a = 16'haaaa;
    logic [15:0] i_pat_b = 16'h5555;
    ddc_pkg::ddc_iq_t i_dc2 = 32'h1234_5678;
    logic [7:0] o_reg_rdata;
    logic [7:0] o_phase_offset_msb;
    logic o_reg_rvalid, i_smp_valid, o_smp_ready, o_out_valid, o_dc2_valid;
    logic [15:0] i_cha, i_chb;
    ddc_pkg::ddc_iq_t o_out, o_dc2;
    ddc_pkg::ddc_if_mode_t o_if_mode;
    logic clr = 1'b1;
    logic src_run = 1'b0;
    logic slow = 1'b0;
    logic stall = 1'b0;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    ddc_pkg::ddc_iq_t got[$];
    // control, input select, expected ratio
    logic [21:0] rows [19] = '{
        {8'h80, 8'h04, 6'h04}, {8'h81, 8'h04, 6'h08}, {8'h82, 8'h04, 6'h10},
        {8'h83, 8'h04, 6'h02}, {8'h8b, 8'h04, 6'h01},
        {8'h84, 8'h04, 6'h06}, {8'hb5, 8'h04, 6'h0c}, {8'h86, 8'h04, 6'h18},
        {8'h87, 8'h04, 6'h30}, {8'h8f, 8'h04, 6'h18},
        {8'h87, 8'h24, 6'h0a}, {8'h87, 8'h34, 6'h14}, {8'h87, 8'h44, 6'h28},
        {8'h0f, 8'h45, 6'h14}, {8'h80, 8'h24, 6'h04},
        {8'h08, 8'h05, 6'h02}, {8'h4e, 8'h04, 6'h0c},
        {8'he3, 8'h01, 6'h02}, {8'h10, 8'h01, 6'h04}
    };
    ddc_top ddc_top_i (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_smp_valid, .i_cha, .i_chb, .o_smp_ready, .o_out_valid, .o_out, .i_out_ready,
        .i_dc2_valid, .i_dc2, .i_pat_a, .i_pat_b, .o_dc2_valid, .o_dc2, .o_phase_offset_msb, .o_if_mode);
    ddc_src_model ddc_src_model_i (.i_mclk, .i_clr(clr), .i_run(src_run), .i_slow(slow),
        .i_ready(o_smp_ready), .o_valid(i_smp_valid), .o_cha(i_cha), .o_chb(i_chb));
    // clock, receiver ready and word capture
    always #2.5 i_mclk = ~i_mclk;
    always @(negedge i_mclk) i_out_ready <= !stall;
    always @(posedge i_mclk) if (o_out_valid === 1'b1 && i_out_ready === 1'b1) got.push_back(o_out);
    // hang guard
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 12000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic do_reset();
        i_arst_n = 1'b0;
        clr = 1'b1;
        src_run = 1'b0;
        repeat (20) @(negedge i_mclk);
        i_arst_n = 1'b1;
        clr = 1'b0;
        repeat (3) @(negedge i_mclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        int k;
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_mclk);
        i_reg_rd = 1'b0;
        for (k = 0; k < 3 && o_reg_rvalid !== 1'b1; k++) @(negedge i_mclk);
        chk(32'(o_reg_rvalid), 32'h0000_0001);
        chk(32'(o_reg_rdata), 32'(e));
    endtask
    task automatic run_stream(input int n);
        int k;
        got.delete();
        src_run = 1'b1;
        for (k = 0; k < 400 && got.size() < n; k++) @(negedge i_mclk);
        src_run = 1'b0;
    endtask
    function automatic logic [15:0] dbl(input logic [15:0] v);
        if ($signed(v) > 16'sh3fff) return 16'h7fff;
        if ($signed(v) < -16'sh4000) return 16'h8000;
        return {v[14:0], 1'b0};
    endfunction
    // kept word j is accepted sample (j+1)*ratio-1
    function automatic logic [31:0] exp_word(input logic [7:0] c, input logic [7:0] s,
        input logic [5:0] r, input int j);
        logic [15:0] n, iv, qv;
        n = 16'((j + 1) * r - 1);
        iv = s[0] ? 16'h7000 + n : 16'h0100 + n;
        qv = c[7] ? (s[2] ? 16'h7000 + n : 16'h0100 + n) : iv;
        if (c[6]) iv = dbl(iv);
        if (c[6]) qv = dbl(qv);
        if (c[3]) qv = 16'h0000;
        if (c[3] && j % 2 == 1) iv = (iv == 16'h8000) ? 16'h7fff : 16'(-iv);
        return {iv, qv};
    endfunction
    initial begin
        logic [7:0] c, s;
        logic [5:0] r;
        for (int x = 0; x < 19; x++) begin
            {c, s, r} = rows[x];
            slow = 1'(x % 2);
            do_reset();
            wr(ddc_pkg::DDC_ADDR_MIX_CTRL, c);
            wr(ddc_pkg::DDC_ADDR_INSEL, s);
            rd(ddc_pkg::DDC_ADDR_INSEL, s);
            chk(32'(o_if_mode), 32'(c[5:4]));
            run_stream(2);
            for (int j = 0; j < 2; j++) chk(got[j], exp_word(c, s, r, j));
            $display("row %0d done", x);
        end
        // defaults after reset, an unmapped byte, reserved bits
        do_reset();
        rd(ddc_pkg::DDC_ADDR_PHASE_MSB, 8'h00);
        rd(ddc_pkg::DDC_ADDR_MIX_CTRL, 8'h00);
        rd(ddc_pkg::DDC_ADDR_TEST_EN, 8'h00);
        rd(ddc_pkg::DDC_ADDR_INSEL, 8'h04);
        rd(16'h0363, 8'h00);
        wr(ddc_pkg::DDC_ADDR_PHASE_MSB, 8'ha5);
        chk(32'(o_phase_offset_msb), 32'h0000_00a5);
        wr(ddc_pkg::DDC_ADDR_INSEL, 8'hff);
        rd(ddc_pkg::DDC_ADDR_INSEL, 8'hf5);
        $display("register test done");
        // every combination of the pattern enables
        for (int t = 0; t < 8; t++) begin
            wr(ddc_pkg::DDC_ADDR_TEST_EN, 8'(t) | 8'hfa);
            rd(ddc_pkg::DDC_ADDR_TEST_EN, 8'(t) & 8'h05);
            @(negedge i_mclk) i_dc2_valid = 1'b1;
            @(negedge i_mclk) i_dc2_valid = 1'b0;
            chk(32'(o_dc2_valid), 32'h0000_0001);
            chk(32'(o_dc2.i), t[0] ? 32'h0000_aaaa : 32'h0000_1234);
            chk(32'(o_dc2.q), t[2] ? 32'h0000_5555 : 32'h0000_5678);
            @(negedge i_mclk);
            chk(32'(o_dc2_valid), 32'h0000_0000);
        end
        $display("pattern test done");
        // receiver stalls until the buffer refuses, then drains with no loss
        do_reset();
        slow = 1'b0;
        wr(ddc_pkg::DDC_ADDR_MIX_CTRL, 8'h83);
        stall = 1'b1;
        src_run = 1'b1;
        repeat (40) @(negedge i_mclk);
        chk(32'(o_smp_ready), 32'h0000_0000);
        stall = 1'b0;
        run_stream(6);
        for (int j = 0; j < 6; j++) chk(got[j], exp_word(8'h83, 8'h04, 6'h02, j));
        $display("stall test done");
        test_done();
    end
endmodule
